// [lsrac_pkg.sv]
// lsrac_pkg: shared constants for the loadable shift register block
// assumes: included before the interface and the modules
package lsrac_pkg;

  // ----------------------------------------------------------------
  // widths and depths
  // ----------------------------------------------------------------
  localparam int LSRAC_MAX_WIDTH = 16;
  localparam int LSRAC_FIFO_DEPTH = 8;
  localparam int LSRAC_FIFO_PTR_W = 3;

  // ----------------------------------------------------------------
  // register map (word addresses are byte offsets, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] LSRAC_CTRL_OFS = 8'h00;
  localparam logic [7:0] LSRAC_DATA_OFS = 8'h04;
  localparam logic [7:0] LSRAC_STAT_OFS = 8'h08;
  localparam logic [7:0] LSRAC_CAPT_OFS = 8'h0C;

  // ----------------------------------------------------------------
  // control register field positions
  // ----------------------------------------------------------------
  localparam int LSRAC_CTRL_CAPT_BIT = 0;
  localparam int LSRAC_CTRL_INV_BIT = 1;
  localparam logic [1:0] LSRAC_CTRL_RESET = 2'h0;

  // ----------------------------------------------------------------
  // status register field positions
  // ----------------------------------------------------------------
  localparam int LSRAC_STAT_EMPTY_BIT = 0;
  localparam int LSRAC_STAT_FULL_BIT = 1;
  localparam int LSRAC_STAT_COUNT_LSB = 4;

  // ----------------------------------------------------------------
  // register file reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] LSRAC_WORD_ZERO = 32'h0000_0000;

endpackage

// [lsrac_stream_if.sv]
// lsrac_stream_if: valid/ready word stream between the shifter and its fifo
// assumes: one clock shared by both ends
`timescale 1ns/1ps
interface lsrac_stream_if;
  logic [lsrac_pkg::LSRAC_MAX_WIDTH-1:0] data;
  logic valid;
  logic ready;

  modport source (output data, output valid, input ready);
  modport sink (input data, input valid, output ready);
endinterface

// [lsrac_fifo.sv]
// lsrac_fifo: synchronous fifo, width and depth by parameter
// assumes: sys_clk domain, synchronous active-high reset
`timescale 1ns/1ps
module lsrac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int PTR_W = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // fill side
  lsrac_stream_if.sink fill,
  // drain side
  output logic [WIDTH-1:0] drainData,
  output logic drainValid,
  input wire logic drainReady,
  // level
  output logic [PTR_W:0] level
);
  import lsrac_pkg::*;

  typedef struct packed {
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W:0] count;
  } lsrac_fifo_state_t;

  lsrac_fifo_state_t st;
  lsrac_fifo_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic doPush;
  logic doPop;

  // handshake terms
  assign fill.ready = (st.count != DEPTH[PTR_W:0]);
  assign drainValid = (st.count != '0);
  assign doPush = fill.valid && fill.ready;
  assign doPop = drainValid && drainReady;
  assign drainData = mem[st.rdPtr];
  assign level = st.count;

  // pointer and count update
  always_comb
  begin
    next_st = st;
    if (doPush)
    begin
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (doPop)
    begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
    if (doPush && !doPop)
    begin
      next_st.count = st.count + 1'b1;
    end
    else if (doPop && !doPush)
    begin
      next_st.count = st.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // storage array
  always_ff @(posedge sys_clk)
  begin
    if (doPush)
    begin
      mem[st.wrPtr] <= fill.data;
    end
  end
endmodule

// [lsrac_shifter.sv]
// lsrac_shifter: loadable serial-in parallel-out shift register with
// asynchronous clear, plus a wishbone slave that snapshots the stages
// into a fifo for software to read.
// assumes: controls come from logic on sys_clk; global nets from the device
// limitation: the capture side sees the stages only at sys_clk edges, so a
// clear that comes and goes between two edges is seen only as the zero stages it leaves at the next edge
//
// What this block does
// - widths 4, 8, 16; serial in, parallel out
// - clear high forces outputs low immediately
// - load copies parallel inputs, overrides enable
// - enabled edge captures serial input into stage zero
// - each stage takes previous lower stage value
// - no load, no enable: outputs hold
// - shift is one simultaneous position move
// - load stores parallel level at edge
// - power-up starts with all stages low
// - global reset net clears, polarity selectable
// - global preload pulse also clears stages
`timescale 1ns/1ps
module lsrac_shifter #(
  parameter int WIDTH = 8,
  parameter bit HAS_LOAD = 1'b1,
  parameter bit GLOBAL_RESET_INVERT = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // device-wide nets
  input wire logic global_reset_net,
  input wire logic global_preload_net,
  // shifter controls
  input wire logic async_clear_in,
  input wire logic clockEnable,
  input wire logic parallel_load,
  input wire logic shift_left_serial_in,
  input wire logic [WIDTH-1:0] parallelIn,
  // shifter outputs
  output logic [WIDTH-1:0] parallelOut,
  output logic cascadeOut,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o
);
  import lsrac_pkg::*;

  // ----------------------------------------------------------------
  // global clear
  // ----------------------------------------------------------------

  // any of the clear sources wipes the stages asynchronously
  logic globalResetActive;
  logic stageClear;
  assign globalResetActive = global_reset_net ^ GLOBAL_RESET_INVERT;
  assign stageClear = async_clear_in | globalResetActive | global_preload_net;

  // ----------------------------------------------------------------
  // shift stages
  // ----------------------------------------------------------------

  logic loadActive;
  logic [WIDTH-1:0] stages = '0; // power-up value of every stage
  logic [WIDTH-1:0] next_stages;
  logic [WIDTH-1:0] shiftSource;

  // without a load port the load term is constant low
  assign loadActive = HAS_LOAD ? parallel_load : 1'b0;

  // per stage next value: load beats shift, shift beats hold
  for (genvar n = 0; n < WIDTH; n++)
  begin : g_stage
    if (n == 0)
    begin : g_first
      // stage zero takes the serial bit
      assign shiftSource[n] = shift_left_serial_in;
    end
    else
    begin : g_upper
      // pre-edge value of the lower neighbour, so no ripple
      assign shiftSource[n] = stages[n-1];
    end
    assign next_stages[n] = loadActive ? parallelIn[n] :
      (clockEnable ? shiftSource[n] : stages[n]);
  end

  // stage flops with asynchronous clear
  always_ff @(posedge sys_clk or posedge stageClear)
  begin
    if (stageClear)
    begin
      stages <= '0;
    end
    else
    begin
      stages <= next_stages;
    end
  end

  // one output per stage, top stage also offered for cascading
  assign parallelOut = stages;
  assign cascadeOut = stages[WIDTH-1];

  // ----------------------------------------------------------------
  // snapshot capture into the fifo
  // ----------------------------------------------------------------

  typedef struct packed {
    logic captureOn;
    logic invertData;
    logic ack;
    logic err;
    logic [31:0] rdData;
    logic [15:0] capturedCount;
    logic [WIDTH-1:0] lastStages;
    logic pendValid;
    logic [LSRAC_MAX_WIDTH-1:0] pendData;
  } lsrac_ctrl_state_t;

  lsrac_ctrl_state_t st;
  lsrac_ctrl_state_t next_st;

  lsrac_stream_if capStream ();
  logic [LSRAC_MAX_WIDTH-1:0] fifoData;
  logic fifoValid;
  logic fifoPop;
  logic [LSRAC_FIFO_PTR_W:0] fifoLevel;
  logic [LSRAC_MAX_WIDTH-1:0] stagesWide;

  assign stagesWide = LSRAC_MAX_WIDTH'(stages);
  assign capStream.data = st.pendData;
  assign capStream.valid = st.pendValid;

  lsrac_fifo #(
    .WIDTH(LSRAC_MAX_WIDTH),
    .DEPTH(LSRAC_FIFO_DEPTH),
    .PTR_W(LSRAC_FIFO_PTR_W)
  ) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .fill(capStream),
    .drainData(fifoData),
    .drainValid(fifoValid),
    .drainReady(fifoPop),
    .level(fifoLevel)
  );

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------

  logic wbReq;
  logic wbWrite;
  logic wbRead;
  logic selLow;
  logic hitCtrl;
  logic hitData;
  logic hitStat;
  logic hitCapt;
  logic hitAny;
  logic tookWord;
  logic [31:0] readWord;

  // a request counts once; the answering cycle is not taken again
  assign wbReq = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
  assign wbWrite = wbReq && wb_we_i;
  assign wbRead = wbReq && !wb_we_i;
  assign selLow = wb_sel_i[0]; // only the low byte lane enables the control and count writes

  // address decode, one word per register
  assign hitCtrl = (wb_adr_i == LSRAC_CTRL_OFS);
  assign hitData = (wb_adr_i == LSRAC_DATA_OFS);
  assign hitStat = (wb_adr_i == LSRAC_STAT_OFS);
  assign hitCapt = (wb_adr_i == LSRAC_CAPT_OFS);
  assign hitAny = hitCtrl || hitData || hitStat || hitCapt;

  // popping the data word consumes one fifo entry
  assign fifoPop = wbRead && hitData && fifoValid;

  // read multiplexer; unused bits and unmapped words read as zero
  always_comb
  begin
    readWord = LSRAC_WORD_ZERO;
    if (hitCtrl)
    begin
      readWord[LSRAC_CTRL_CAPT_BIT] = st.captureOn;
      readWord[LSRAC_CTRL_INV_BIT] = st.invertData;
    end
    else if (hitData)
    begin
      // an empty fifo reads as zero and is not popped
      readWord[LSRAC_MAX_WIDTH-1:0] = fifoValid ? fifoData : '0;
    end
    else if (hitStat)
    begin
      readWord[LSRAC_STAT_EMPTY_BIT] = !fifoValid;
      readWord[LSRAC_STAT_FULL_BIT] = !capStream.ready;
      readWord[LSRAC_STAT_COUNT_LSB +: LSRAC_FIFO_PTR_W + 1] = fifoLevel;
    end
    else if (hitCapt)
    begin
      readWord[15:0] = st.capturedCount;
    end
  end

  // register file and capture control
  always_comb
  begin
    next_st = st;
    tookWord = 1'b0;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;
    next_st.lastStages = stages;
    // a pending word waits while the fifo is full, new changes are dropped
    if (st.pendValid && capStream.ready)
    begin
      next_st.pendValid = 1'b0;
    end
    // a change is taken only when the pending slot is free this cycle
    if (st.captureOn && (stages != st.lastStages) && !next_st.pendValid)
    begin
      tookWord = 1'b1;
      next_st.pendValid = 1'b1;
      next_st.pendData = st.invertData ? ~stagesWide : stagesWide;
      next_st.capturedCount = st.capturedCount + 16'h0001;
    end
    // every taken request answers next cycle with ack or err
    if (wbReq)
    begin
      next_st.rdData = readWord;
      next_st.ack = hitAny;
      next_st.err = !hitAny; // unmapped address answers with err
    end
    // control write; writes without the low lane are acked and ignored
    if (wbWrite && selLow && hitCtrl)
    begin
      next_st.captureOn = wb_dat_i[LSRAC_CTRL_CAPT_BIT];
      next_st.invertData = wb_dat_i[LSRAC_CTRL_INV_BIT];
    end
    // write clears the count; a word taken in that cycle still counts
    if (wbWrite && selLow && hitCapt)
    begin
      next_st.capturedCount = {15'h0000, tookWord};
    end
  end

  // control state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.captureOn <= LSRAC_CTRL_RESET[LSRAC_CTRL_CAPT_BIT];
      st.invertData <= LSRAC_CTRL_RESET[LSRAC_CTRL_INV_BIT];
    end
    else
    begin
      st <= next_st;
    end
  end

  // bus outputs straight from flops
  assign wb_ack_o = st.ack;
  assign wb_err_o = st.err;
  assign wb_dat_o = st.rdData;
endmodule

// [lsrac_monitor.sv]
// lsrac_monitor: port assertions for the shifter
// assumes: bound into every lsrac_shifter, sys_clk domain
`timescale 1ns/1ps
module lsrac_monitor #(
  parameter int WIDTH = 8,
  parameter bit HAS_LOAD = 1'b1,
  parameter bit GLOBAL_RESET_INVERT = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // stage controls
  input wire logic global_reset_net,
  input wire logic global_preload_net,
  input wire logic async_clear_in,
  input wire logic clockEnable,
  input wire logic parallel_load,
  input wire logic shift_left_serial_in,
  input wire logic [WIDTH-1:0] parallelIn,
  // stage outputs
  input wire logic [WIDTH-1:0] parallelOut,
  input wire logic cascadeOut,
  // bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o
);
  logic anyClr;
  logic loadOn;
  logic idle;
  // -------------------------------------------
  // helpers
  // -------------------------------------------
  // any of the three stage clears, and an edge with no load or clear
  assign anyClr = async_clear_in | global_preload_net | (global_reset_net ^ GLOBAL_RESET_INVERT);
  assign loadOn = HAS_LOAD && parallel_load;
  assign idle = !anyClr && !loadOn;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // -------------------------------------------
  // stage behaviour
  // -------------------------------------------
  property p_clear; anyClr |-> parallelOut == '0; endproperty
  a_clear: assert property (p_clear)
    else $error("stages not cleared");
  property p_load;
    !anyClr && loadOn ##1 !anyClr |-> parallelOut == $past(parallelIn);
  endproperty
  a_load: assert property (p_load)
    else $error("load value wrong");
  property p_first;
    idle && clockEnable ##1 !anyClr |-> parallelOut[0] == $past(shift_left_serial_in);
  endproperty
  a_first: assert property (p_first)
    else $error("serial bit not captured");
  property p_move;
    idle && clockEnable ##1 !anyClr |-> parallelOut[WIDTH-1:1] == $past(parallelOut[WIDTH-2:0]);
  endproperty
  a_move: assert property (p_move)
    else $error("shift move wrong");
  property p_hold;
    idle && !clockEnable ##1 !anyClr |-> $stable(parallelOut);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stages changed while idle");
  property p_top; cascadeOut == parallelOut[WIDTH-1]; endproperty
  a_top: assert property (p_top)
    else $error("cascade not top stage");
  // -------------------------------------------
  // bus answer
  // -------------------------------------------
  property p_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse)
    else $error("ack longer than one cycle");
endmodule
bind lsrac_shifter lsrac_monitor #(.WIDTH(WIDTH), .HAS_LOAD(HAS_LOAD),
  .GLOBAL_RESET_INVERT(GLOBAL_RESET_INVERT))
  u_lsrac_monitor (.sys_clk, .sys_rst, .global_reset_net, .global_preload_net, .async_clear_in,
  .clockEnable, .parallel_load, .shift_left_serial_in, .parallelIn, .parallelOut, .cascadeOut,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o);

// [lsrac_user_model.sv]
// lsrac_user_model: next stage of a cascade in the user logic
// assumes: shares clock, enable, load and clear with the shifter
`timescale 1ns/1ps
module lsrac_user_model (
  // clock and shared controls
  input wire logic sys_clk,
  input wire logic clearIn,
  input wire logic enableIn,
  input wire logic loadIn,
  // cascade link
  input wire logic serialIn,
  output logic [3:0] stages
);
  // -------------------------------------------
  // downstream stage fed by the top output
  // -------------------------------------------
  always_ff @(posedge sys_clk or posedge clearIn)
  begin
    if (clearIn)
      stages <= 4'h0; // shared clear
    else if (enableIn && !loadIn)
      stages <= {stages[2:0], serialIn}; // top output into serial input
  end
endmodule

// [lsrac_shifter_test.sv]
// lsrac_shifter_test: bench for the shifter, its registers and fifo
// assumes: package, interface, fifo, shifter, model and monitor compiled
`timescale 1ns/1ps
module lsrac_shifter_test;
  import lsrac_pkg::*;
  logic sysClk, sysRst, gRst, gPre, clr, en, ld, sin, cyc, stb, we, ack, err, casc, lastErr;
  logic [7:0] pin, pout, adr;
  logic [3:0] sel, user;
  logic [31:0] wdat, rdat, q;
  int failCount = 0;
  int samplesChecked = 0;
  lsrac_shifter #(.WIDTH(8)) u_lsrac_shifter (.sys_clk(sysClk), .sys_rst(sysRst),
    .global_reset_net(gRst), .global_preload_net(gPre), .async_clear_in(clr),
    .clockEnable(en), .parallel_load(ld), .shift_left_serial_in(sin), .parallelIn(pin),
    .parallelOut(pout), .cascadeOut(casc), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err));
  lsrac_user_model u_lsrac_user_model (.sys_clk(sysClk), .clearIn(clr), .enableIn(en),
    .loadIn(ld), .serialIn(casc), .stages(user));
  // -------------------------------------------
  // clock, compare, verdict
  // -------------------------------------------
  initial
  begin
    sysClk = 1'b0;
    forever #5 sysClk = ~sysClk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      failCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic giveVerdict();
    $display("compares %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one classic wishbone cycle, held until ack or err
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sysClk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
    do
    begin
      @(posedge sysClk);
      n++;
    end
    while ((ack | err) !== 1'b1 && n < 16);
    if ((ack | err) !== 1'b1)
    begin
      failCount++;
      giveVerdict();
    end
    else
    begin
      q = rdat;
      lastErr = err;
      {cyc, stb, we} <= 3'b000;
    end
  endtask
  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial
  begin
    sysRst = 1'b1;
    {gRst, gPre, clr, en, ld, sin, cyc, stb, we} = 9'h000;
    {pin, adr, sel, wdat} = 52'h0;
    repeat (4) @(posedge sysClk);
    sysRst <= 1'b0;
    @(negedge sysClk);
    check(pout, 8'h00);
    bus(1'b0, LSRAC_STAT_OFS, 4'hF, 32'h0);
    check(q, 32'(1 << LSRAC_STAT_EMPTY_BIT));
    // load beats enable, one shift, then a hold
    @(posedge sysClk);
    {ld, en, pin} <= {2'b11, 8'hA5};
    @(posedge sysClk);
    {ld, sin} <= 2'b01;
    @(negedge sysClk);
    check(pout, 8'hA5);
    @(posedge sysClk);
    en <= 1'b0;
    @(negedge sysClk);
    check(pout, 8'((8'hA5 << 1) | 8'h01));
    repeat (2) @(negedge sysClk);
    check(pout, 8'((8'hA5 << 1) | 8'h01));
    // each clear acts at once and beats load
    for (int k = 0; k < 3; k++)
    begin
      @(posedge sysClk);
      {ld, pin} <= {1'b1, 8'hFF};
      @(posedge sysClk);
      {gRst, gPre, clr} <= 3'(1 << k);
      #2 check(pout, 8'h00);
      @(posedge sysClk);
      {gRst, gPre, clr, ld} <= 4'h0;
      @(negedge sysClk);
      check(pout, 8'h00);
    end
    // top stage feeds the downstream model
    @(posedge sysClk);
    {ld, pin} <= {1'b1, 8'h80};
    @(posedge sysClk);
    {ld, en, sin} <= 3'b010;
    @(posedge sysClk);
    en <= 1'b0;
    @(negedge sysClk);
    check(user, 4'h1);
    check(pout, 8'h00);
    // registers, masked write, fifo fill and drain
    bus(1'b1, LSRAC_CTRL_OFS, 4'hF, 32'h1);
    bus(1'b1, LSRAC_CTRL_OFS, 4'hE, 32'h0);
    bus(1'b0, LSRAC_CTRL_OFS, 4'hF, 32'h0);
    check(q, 32'h1);
    for (int i = 1; i < 10; i++)
    begin
      @(posedge sysClk);
      {ld, pin} <= {1'b1, 8'(i)};
      @(posedge sysClk);
      ld <= 1'b0;
      repeat (2) @(posedge sysClk);
    end
    bus(1'b0, LSRAC_STAT_OFS, 4'hF, 32'h0);
    check(q, 32'(1 << LSRAC_STAT_FULL_BIT) | 32'(LSRAC_FIFO_DEPTH << LSRAC_STAT_COUNT_LSB));
    for (int i = 1; i < 9; i++)
    begin
      bus(1'b0, LSRAC_DATA_OFS, 4'hF, 32'h0);
      check(q, 32'(i));
    end
    bus(1'b0, 8'h10, 4'hF, 32'h0);
    check(32'(lastErr), 32'h1);
    // the stalled ninth word, then an empty read
    bus(1'b0, LSRAC_DATA_OFS, 4'hF, 32'h0);
    check(q, 32'h9);
    bus(1'b0, LSRAC_DATA_OFS, 4'hF, 32'h0);
    check(q, 32'h0);
    // inverted capture of one load, then the capture count
    bus(1'b1, LSRAC_CTRL_OFS, 4'h1, 32'h3);
    @(posedge sysClk);
    {ld, pin} <= {1'b1, 8'h5A};
    @(posedge sysClk);
    ld <= 1'b0;
    repeat (2) @(posedge sysClk);
    bus(1'b0, LSRAC_DATA_OFS, 4'hF, 32'h0);
    check(q, 32'h0000_FFA5);
    bus(1'b0, LSRAC_CAPT_OFS, 4'hF, 32'h0);
    check(q, 32'hA);
    bus(1'b1, LSRAC_CAPT_OFS, 4'hF, 32'h0);
    bus(1'b0, LSRAC_CAPT_OFS, 4'hF, 32'h0);
    check(q, 32'h0);
    // bus reset in mid-run clears registers but not the stages
    @(posedge sysClk);
    sysRst <= 1'b1;
    repeat (2) @(posedge sysClk);
    sysRst <= 1'b0;
    bus(1'b0, LSRAC_CTRL_OFS, 4'hF, 32'h0);
    check(q, 32'h0);
    check(pout, 8'h5A);
    giveVerdict();
  end
endmodule
